// ---- cio_pkg.sv ----
// Purpose: shared constants of the camera line i/o and pulse generators
// Assumes: 32-bit classic wishbone, one clock at 125 MHz
// Notes:   offsets are byte addresses of aligned words
//
// Contract
// - input line levels at bits 3, 4, 13
// - output line levels at bits 0, 11
// - low reads as 0, high as 1
// - exposure window routable to connector outputs
// - window covers exposure plus sensor offset time
// - selector picks common, red, green or blue window
// - common follows longest exposure channel
// - clear source chosen from listed internal signals
// - generator never clears from its own output
// - generator has rise, fall, period, span, sync mode
`default_nettype none
package cio_pkg;
  localparam int CIO_NPG = 4;
  localparam int CIO_CW  = 16; // generator count width
  localparam int CIO_SW  = 5;  // source code width
  localparam int CIO_NSRC = 18;
  // register byte offsets
  localparam logic [7:0] CIO_A_LEVELS = 8'h00;
  localparam logic [7:0] CIO_A_OUTSEL = 8'h04;
  localparam logic [7:0] CIO_A_EXPO   = 8'h08;
  localparam logic [7:0] CIO_A_PGCLR  = 8'h0C;
  localparam logic [7:0] CIO_A_PGBASE = 8'h10; // + 16*g
  localparam logic [3:0] CIO_A_RISE   = 4'h0;
  localparam logic [3:0] CIO_A_FALL   = 4'h4;
  localparam logic [3:0] CIO_A_PER    = 4'h8;
  localparam logic [3:0] CIO_A_SPAN   = 4'hC;
  // packed line level bit positions
  localparam int CIO_B_OUT1 = 0;
  localparam int CIO_B_IN1  = 3;
  localparam int CIO_B_OPT1 = 4;
  localparam int CIO_B_OUT4 = 11;
  localparam int CIO_B_IN4  = 13;
  // output select fields
  localparam int CIO_F_SEL1 = 0;
  localparam int CIO_F_INV1 = 5;
  localparam int CIO_F_SEL4 = 8;
  localparam int CIO_F_INV4 = 13;
  // exposure control fields
  localparam int CIO_F_CHSEL = 0;
  localparam int CIO_F_PERCH = 2;
  localparam int CIO_F_SWOUT = 4;
  // clear control: one byte per generator
  localparam int CIO_F_CLRSEL = 0;
  localparam int CIO_F_ASYNC  = 5;
  localparam int CIO_CLR_STEP = 8;
  // internal source codes, shared by outputs and clears
  localparam logic [4:0] CIO_S_EXPO = 5'h00;
  localparam logic [4:0] CIO_S_LINE_VALID_STROBE = 5'h01;
  localparam logic [4:0] CIO_S_PG0  = 5'h02;
  localparam logic [4:0] CIO_S_SW0  = 5'h06;
  localparam logic [4:0] CIO_S_IN1  = 5'h0A;
  localparam logic [4:0] CIO_S_OPT1 = 5'h0B;
  localparam logic [4:0] CIO_S_IN4  = 5'h0C;
  localparam logic [4:0] CIO_S_LB0  = 5'h0D;
  localparam logic [4:0] CIO_S_ENC  = 5'h11;
  localparam logic [4:0] CIO_S_NONE = 5'h1F;
  // reset values
  localparam logic [31:0] CIO_R_OUTSEL = 32'h00001F1F;
  localparam logic [31:0] CIO_R_EXPO   = 32'h00000000;
  localparam logic [31:0] CIO_R_PGCLR  = 32'h1F1F1F1F;
  localparam logic [15:0] CIO_R_PER    = 16'h000A;
  localparam logic [15:0] CIO_R_ZERO   = 16'h0000;
  typedef enum logic [1:0] {
    CIO_CH_COMMON = 2'h0,
    CIO_CH_RED    = 2'h1,
    CIO_CH_GREEN  = 2'h2,
    CIO_CH_BLUE   = 2'h3
  } cio_chsel_t;
endpackage
`default_nettype wire

// ---- cio_pg_if.sv ----
// Purpose: settings and output of one pulse generator
// Assumes: driven by the top, read by the generator
// Notes:   ctl side drives settings, pg side drives pulse
`timescale 1ns/100ps
`default_nettype none
interface cio_pg_if;
  import cio_pkg::*;
  logic [CIO_CW-1:0] rise;
  logic [CIO_CW-1:0] fall;
  logic [CIO_CW-1:0] period;
  logic [CIO_CW-1:0] span;
  logic              clr;
  logic              async_clr;
  logic              pulse;
  modport ctl (output rise, fall, period, span, clr, async_clr,
               input pulse);
  modport pg  (input rise, fall, period, span, clr, async_clr,
               output pulse);
endinterface
`default_nettype wire

// ---- cio_pulse_gen.sv ----
// Purpose: one periodic pulse generator with restart on clear
// Assumes: clear source already picked and free of own output
// Notes:   period 0 behaves as period 1
`timescale 1ns/100ps
`default_nettype none
module cio_pulse_gen
  import cio_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  cio_pg_if.pg      pg
);
  logic [CIO_CW-1:0] cnt_r;
  logic              clr_d_r;
  logic              pulse_r;
  logic              restart;
  logic [CIO_CW-1:0] stop;
  logic [CIO_CW-1:0] last;

  // synced mode restarts on a rising clear, async holds while high
  assign restart = pg.async_clr ? pg.clr : (pg.clr & ~clr_d_r);
  // a nonzero span overrides the fall point
  assign stop = (pg.span != CIO_R_ZERO) ?
                CIO_CW'(pg.rise + pg.span) : pg.fall;
  assign last = (pg.period == CIO_R_ZERO) ?
                CIO_R_ZERO : CIO_CW'(pg.period - 1'b1);

  // edge memory for synced clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_d_r <= 1'b0;
    end else begin
      clr_d_r <= pg.clr;
    end
  end

  // period counter, restarted by clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= CIO_R_ZERO;
    end else if (restart || cnt_r >= last) begin
      cnt_r <= CIO_R_ZERO;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // output high between rise and stop in each period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= ~(pg.async_clr & pg.clr) &
                 (cnt_r >= pg.rise) & (cnt_r < stop);
    end
  end

  assign pg.pulse = pulse_r;
endmodule
`default_nettype wire

// ---- cio_top.sv ----
// Purpose: camera line i/o routing, exposure window and pulse generators
// Assumes: sensor channel windows and strobes come from this clock
// Notes:   registers on classic wishbone, ack one cycle after request
`timescale 1ns/100ps
`default_nettype none
module cio_top
  import cio_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // connector pins
  input  wire logic        ttl_in1_i,
  input  wire logic        opto_in1_i,
  input  wire logic        ttl_in4_i,
  output logic             ttl_out1_o,
  output logic             ttl_out4_o,
  // internal signals from the camera core
  input  wire logic [2:0]  expo_ch_i,
  input  wire logic        line_valid_strobe_i,
  input  wire logic [3:0]  logic_block_i,
  input  wire logic        encoder_derived_trigger_i
);
  // registers
  logic [31:0]       outsel_r;
  logic [31:0]       expo_r;
  logic [31:0]       pgclr_r;
  logic [CIO_CW-1:0] rise_r   [CIO_NPG];
  logic [CIO_CW-1:0] fall_r   [CIO_NPG];
  logic [CIO_CW-1:0] period_r [CIO_NPG];
  logic [CIO_CW-1:0] span_r   [CIO_NPG];
  logic              ack_r;
  logic [31:0]       dat_r;
  // pin synchronisers
  logic [2:0]        pin_s1_r;
  logic [2:0]        pin_s2_r;
  // routing
  logic [CIO_NSRC-1:0] src;
  logic [CIO_NPG-1:0]  pg_out;
  logic                expo_win;
  logic                out1_r;
  logic                out4_r;
  logic [31:0]         levels;
  logic                req;
  logic [3:0]          pg_idx;
  logic                pg_hit;

  // pick one source by code; unknown codes give low
  function automatic logic src_pick(input logic [CIO_NSRC-1:0] s,
                                    input logic [CIO_SW-1:0] code);
    src_pick = (32'(code) < CIO_NSRC) ? s[code] : 1'b0;
  endfunction

  // merge write data into a word under byte enables
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {ttl_in4_i, opto_in1_i, ttl_in1_i};
      pin_s2_r <= pin_s1_r;
    end
  end

  // exposure window; sensor channel windows already carry the offset
  // time, so the routed signal spans exposure plus offset
  always_comb begin
    unique case (cio_chsel_t'(expo_r[CIO_F_CHSEL +: 2]))
      // all channels end together, so the union tracks the
      // channel that started first, i.e. the longest one
      CIO_CH_COMMON: expo_win = expo_r[CIO_F_PERCH] ?
                                (|expo_ch_i) : expo_ch_i[0];
      CIO_CH_RED:    expo_win = expo_ch_i[0];
      CIO_CH_GREEN:  expo_win = expo_ch_i[1];
      CIO_CH_BLUE:   expo_win = expo_ch_i[2];
    endcase
  end
  // note: is met by taking the sensor window, not a timer

  // shared source bus for output routing and generator clears
  always_comb begin
    src = '0;
    src[CIO_S_EXPO] = expo_win;
    src[CIO_S_LINE_VALID_STROBE] = line_valid_strobe_i;
    src[CIO_S_PG0 +: CIO_NPG] = pg_out;
    src[CIO_S_SW0 +: 4] = expo_r[CIO_F_SWOUT +: 4];
    src[CIO_S_IN1]  = pin_s2_r[0];
    src[CIO_S_OPT1] = pin_s2_r[1];
    src[CIO_S_IN4]  = pin_s2_r[2];
    src[CIO_S_LB0 +: 4] = logic_block_i;
    src[CIO_S_ENC]  = encoder_derived_trigger_i;
  end

  // pulse generators, each on its own settings bundle
  for (genvar g = 0; g < CIO_NPG; g++) begin : g_pg
    cio_pg_if pif ();
    logic [CIO_SW-1:0] csel;
    assign csel = pgclr_r[g*CIO_CLR_STEP + CIO_F_CLRSEL +: CIO_SW];
    assign pif.rise   = rise_r[g];
    assign pif.fall   = fall_r[g];
    assign pif.period = period_r[g];
    assign pif.span   = span_r[g];
    // own output as clear is refused: it would restart itself on each of its own pulses
    assign pif.clr = (csel == CIO_SW'(CIO_S_PG0 + g)) ? 1'b0 :
                     src_pick(src, csel);
    assign pif.async_clr = pgclr_r[g*CIO_CLR_STEP + CIO_F_ASYNC];
    assign pg_out[g] = pif.pulse;
    cio_pulse_gen u_pg (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pg    (pif.pg)
    );
  end

  // output lines: selected source, optional inversion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out1_r <= 1'b0;
      out4_r <= 1'b0;
    end else begin
      out1_r <= src_pick(src, outsel_r[CIO_F_SEL1 +: CIO_SW]) ^
                outsel_r[CIO_F_INV1];
      out4_r <= src_pick(src, outsel_r[CIO_F_SEL4 +: CIO_SW]) ^
                outsel_r[CIO_F_INV4];
    end
  end
  assign ttl_out1_o = out1_r;
  assign ttl_out4_o = out4_r;

  // packed levels: high reads 1, low reads 0, no inversion on inputs
  always_comb begin
    levels = '0;
    levels[CIO_B_OUT1] = out1_r;
    levels[CIO_B_OUT4] = out4_r;
    levels[CIO_B_IN1]  = pin_s2_r[0];
    levels[CIO_B_OPT1] = pin_s2_r[1];
    levels[CIO_B_IN4]  = pin_s2_r[2];
  end

  // bus decode
  assign req    = cyc_i & stb_i & ~ack_r;
  assign pg_idx = 4'(adr_i[7:4] - 4'h1);
  assign pg_hit = (adr_i >= CIO_A_PGBASE) &&
                  (32'(pg_idx) < CIO_NPG) && (adr_i[1:0] == 2'b00);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end
  assign ack_o = ack_r;

  // read data captured with the request; unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h00000000;
    end else if (req) begin
      dat_r <= 32'h00000000;
      if (pg_hit) begin
        unique case (adr_i[3:0])
          CIO_A_RISE: dat_r <= 32'(rise_r[pg_idx[1:0]]);
          CIO_A_FALL: dat_r <= 32'(fall_r[pg_idx[1:0]]);
          CIO_A_PER:  dat_r <= 32'(period_r[pg_idx[1:0]]);
          CIO_A_SPAN: dat_r <= 32'(span_r[pg_idx[1:0]]);
          default:    dat_r <= 32'h00000000;
        endcase
      end else begin
        unique case (adr_i)
          CIO_A_LEVELS: dat_r <= levels;
          CIO_A_OUTSEL: dat_r <= outsel_r;
          CIO_A_EXPO:   dat_r <= expo_r;
          CIO_A_PGCLR:  dat_r <= pgclr_r;
          default:      dat_r <= 32'h00000000;
        endcase
      end
    end
  end
  assign dat_o = dat_r;

  // control registers; writes land with the request cycle, the
  // value is visible before the master samples ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      outsel_r <= CIO_R_OUTSEL;
      expo_r   <= CIO_R_EXPO;
      pgclr_r  <= CIO_R_PGCLR;
    end else if (req && we_i) begin
      if (adr_i == CIO_A_OUTSEL) begin
        outsel_r <= wmerge(outsel_r, dat_i, sel_i);
      end
      if (adr_i == CIO_A_EXPO) begin
        expo_r <= wmerge(expo_r, dat_i, sel_i);
      end
      if (adr_i == CIO_A_PGCLR) begin
        pgclr_r <= wmerge(pgclr_r, dat_i, sel_i);
      end
    end
  end

  // generator settings, low half-word only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < CIO_NPG; g++) begin
        rise_r[g]   <= CIO_R_ZERO;
        fall_r[g]   <= CIO_R_ZERO;
        period_r[g] <= CIO_R_PER;
        span_r[g]   <= CIO_R_ZERO;
      end
    end else if (req && we_i && pg_hit) begin
      unique case (adr_i[3:0])
        // upper half-word of the merged word is dropped on purpose
        CIO_A_RISE: rise_r[pg_idx[1:0]] <=
                      CIO_CW'(wmerge(32'(rise_r[pg_idx[1:0]]),
                                     dat_i, sel_i));
        CIO_A_FALL: fall_r[pg_idx[1:0]] <=
                      CIO_CW'(wmerge(32'(fall_r[pg_idx[1:0]]),
                                     dat_i, sel_i));
        CIO_A_PER:  period_r[pg_idx[1:0]] <=
                      CIO_CW'(wmerge(32'(period_r[pg_idx[1:0]]),
                                     dat_i, sel_i));
        CIO_A_SPAN: span_r[pg_idx[1:0]] <=
                      CIO_CW'(wmerge(32'(span_r[pg_idx[1:0]]),
                                     dat_i, sel_i));
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- cio_top_monitor.sv ----
// Purpose: bus and line level checks at the cio_top ports
// Assumes: one clock, synchronous active-high reset
// Notes:   level reads are trusted only after pins sat still 4 cycles
`timescale 1ns/100ps
`default_nettype none
module cio_top_monitor
  import cio_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        ttl_in1_i,
  input wire logic        opto_in1_i,
  input wire logic        ttl_in4_i,
  input wire logic        ttl_out1_o,
  input wire logic        ttl_out4_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request counts once, at the edge where ack is still low
  logic take;
  logic lv_rd;
  assign take  = cyc_i & stb_i & ~ack_o;
  assign lv_rd = take & ~we_i & (adr_i == CIO_A_LEVELS);

  ack_after_take_a: assert property (take |=> ack_o)
    else $error("no ack one cycle after request");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(take))
    else $error("ack without a request");
  dat_hold_a: assert property (!take |=> $stable(dat_o))
    else $error("read data moved without a request");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
      (dat_o == 32'h0 && !ack_o && !ttl_out1_o && !ttl_out4_o))
    else $error("outputs not quiet after reset");
  lv_out_a: assert property (lv_rd |=>
      dat_o[0] == $past(ttl_out1_o) && dat_o[11] == $past(ttl_out4_o))
    else $error("output levels misreported");
  lv_in_a: assert property (
      ($stable({ttl_in4_i, opto_in1_i, ttl_in1_i})[*4] ##0 lv_rd) |=>
      {dat_o[13], dat_o[4], dat_o[3]} ==
      $past({ttl_in4_i, opto_in1_i, ttl_in1_i}))
    else $error("input levels misreported");
  unmapped_zero_a: assert property
      ((take && !we_i && adr_i == 8'hFC) |=> dat_o == 32'h0)
    else $error("unmapped read not zero");

  cover property (take && we_i);
  cover property (lv_rd);
  cover property (ttl_out1_o ##1 !ttl_out1_o);
endmodule
bind cio_top cio_top_monitor i_cio_top_monitor (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .ttl_in1_i(ttl_in1_i),
  .opto_in1_i(opto_in1_i), .ttl_in4_i(ttl_in4_i),
  .ttl_out1_o(ttl_out1_o), .ttl_out4_o(ttl_out4_o));
`default_nettype wire

// ---- cio_line_partner.sv ----
// Purpose: far side of the connector: trigger lines and a lamp
// Assumes: lamp follows the first ttl output, pins are push-pull
// Notes:   lamp on-time counts only while run is high
`timescale 1ns/100ps
`default_nettype none
module cio_line_partner (
  input  wire logic       clk_i,
  input  wire logic [2:0] pattern_i,
  input  wire logic       run_i,
  input  wire logic       lamp_i,
  output logic            ttl_in1_o,
  output logic            opto_in1_o,
  output logic            ttl_in4_o,
  output logic [7:0]      lamp_cnt_o
);
  // trigger sources hold a steady pattern
  assign ttl_in1_o  = pattern_i[0];
  assign opto_in1_o = pattern_i[1];
  assign ttl_in4_o  = pattern_i[2];
  // cleared between runs so each run stands alone
  always_ff @(posedge clk_i) begin
    if (!run_i)
      lamp_cnt_o <= 8'h00;
    else
      lamp_cnt_o <= lamp_cnt_o + {7'h00, lamp_i};
  end
endmodule
`default_nettype wire

// ---- test_camera_io_signal_routing.sv ----
// Purpose: self-checking bench for the camera line i/o block
// Assumes: ack follows one cycle after a taken request
// Notes:   pulse checks count lamp cycles over two full periods
`timescale 1ns/100ps
`default_nettype none
module test_camera_io_signal_routing;
  import cio_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc_i = 1'h0;
  logic        stb_i = 1'h0;
  logic        we_i  = 1'h0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [2:0]  expo_ch_i = 3'h0;
  logic [2:0]  pat = 3'h0;
  logic        run = 1'h0;
  logic        lvs = 1'h0;
  logic [3:0]  lb = 4'h0;
  logic        enc = 1'h0;
  logic [31:0] dat_o;
  logic        ack_o, ttl_out1_o, ttl_out4_o;
  logic        in1, opto, in4;
  logic [7:0]  lamp_cnt;
  int          mismatches = 0;
  int          checked = 0;
  int          cycles = 0;

  cio_top i_cio_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ttl_in1_i(in1),
    .opto_in1_i(opto), .ttl_in4_i(in4), .ttl_out1_o(ttl_out1_o),
    .ttl_out4_o(ttl_out4_o), .expo_ch_i(expo_ch_i),
    .line_valid_strobe_i(lvs), .logic_block_i(lb),
    .encoder_derived_trigger_i(enc));
  cio_line_partner i_cio_line_partner (.clk_i(clk_i), .pattern_i(pat),
    .run_i(run), .lamp_i(ttl_out1_o), .ttl_in1_o(in1),
    .opto_in1_o(opto), .ttl_in4_o(in4), .lamp_cnt_o(lamp_cnt));

  initial forever #4 clk_i = ~clk_i;

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // a hang ends the run as a failure
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1);
    q = dat_o;
    // ack must come exactly one cycle after the taken edge
    chk(32'(n), 32'h2);
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask

  task automatic pins(input logic [1:0] e);
    repeat (2) @(posedge clk_i);
    chk({30'h0, ttl_out4_o, ttl_out1_o}, {30'h0, e});
  endtask

  // lamp cycles over exactly two periods of ten; two settle cycles
  // first so a setting just written has reached the pin
  task automatic lamp(input logic [7:0] e);
    repeat (2) @(posedge clk_i);
    run <= 1'h1;
    repeat (20) @(posedge clk_i);
    run <= 1'h0;
    @(posedge clk_i);
    chk({24'h0, lamp_cnt}, {24'h0, e});
  endtask

  task automatic t_reset;
    rd(CIO_A_OUTSEL, CIO_R_OUTSEL);
    rd(CIO_A_PGCLR, CIO_R_PGCLR);
    rd(8'h48, {16'h0, CIO_R_PER});
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    wr(CIO_A_LEVELS, 32'hFFFFFFFF);
    rd(CIO_A_LEVELS, 32'h0);
  endtask

  task automatic t_inputs;
    for (int i = 0; i < 8; i++) begin
      pat <= i[2:0];
      repeat (4) @(posedge clk_i);
      rd(CIO_A_LEVELS, {18'h0, i[2], 8'h0, i[1], i[0], 3'h0});
    end
  endtask

  // out1 from software bit 0, out4 from inverted software bit 1
  task automatic t_outputs;
    logic [31:0] q;
    wr(CIO_A_EXPO, 32'h10);
    wr(CIO_A_OUTSEL, 32'h00002706);
    pins(2'h3);
    rd(CIO_A_LEVELS, 32'h00002819);
    wb(1'h1, CIO_A_OUTSEL, 32'hFFFF0026, 4'h1, q);
    pins(2'h2);
    rd(CIO_A_OUTSEL, 32'h00002726);
  endtask

  // green window only while walking the channel selector, then red window only
  task automatic t_expo;
    logic [3:0] m;
    wr(CIO_A_OUTSEL, 32'h00001F00);
    expo_ch_i <= 3'h2;
    for (int k = 0; k < 5; k++) begin
      m = (k < 4) ? (4'h4 | k[3:0]) : 4'h0;
      wr(CIO_A_EXPO, {28'h0, m});
      pins({1'h0, k == 0 || k == 2});
    end
    expo_ch_i <= 3'h1;
    pins(2'h1);
  endtask

  task automatic t_pulse;
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h6);
    wr(8'h18, 32'hA);
    wr(8'h1C, 32'h4);
    wr(CIO_A_OUTSEL, 32'h00001F02);
    wr(CIO_A_EXPO, 32'h0);
    lamp(8'h08);
    wr(CIO_A_PGCLR, 32'h1F1F1F02);
    lamp(8'h08);
    wr(CIO_A_PGCLR, 32'h1F1F1F26);
    wr(CIO_A_EXPO, 32'h10);
    lamp(8'h00);
    wr(CIO_A_PGCLR, 32'h1F1F1F06);
    lamp(8'h08);
  endtask

  // core-side sources on out4; a line valid pulse restarts generator 0,
  // whose output on out1 then rises a fixed number of cycles later
  task automatic t_sources;
    wr(CIO_A_PGCLR, {24'h1F1F1F, 3'h0, CIO_S_LINE_VALID_STROBE});
    wr(CIO_A_OUTSEL, {19'h0, CIO_S_LINE_VALID_STROBE, 3'h0, CIO_S_PG0});
    lvs <= 1'h1;
    @(posedge clk_i);
    lvs <= 1'h0;
    @(posedge clk_i);
    chk({31'h0, ttl_out4_o}, 32'h1);
    @(posedge clk_i);
    chk({31'h0, ttl_out4_o}, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, ttl_out1_o}, 32'h0);
    @(posedge clk_i);
    chk({31'h0, ttl_out1_o}, 32'h1);
    wr(CIO_A_OUTSEL, {19'h0, CIO_S_ENC, 8'h1F});
    enc <= 1'h1;
    pins(2'h2);
    wr(CIO_A_OUTSEL, {19'h0, CIO_S_LB0 + 5'h3, 8'h1F});
    lb <= 4'h8;
    pins(2'h2);
    lb <= 4'h7;
    pins(2'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_inputs();
    t_outputs();
    t_expo();
    t_pulse();
    t_sources();
    stop_test();
  end
endmodule
`default_nettype wire
